// ---- include/posm_pkg.sv ----
/*
  Package for the pin output source multiplexer: register map, field layout,
  reset values and source selector codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addressing.
*/
package posm_pkg;

  localparam int NUM_PORTS = 5;
  localparam int PINS_PER_PORT = 8;
  localparam int NUM_PINS = NUM_PORTS * PINS_PER_PORT;
  localparam int SEL_W = 5;
  localparam int NUM_SRC = 23;

  // Port indices
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;

  // Register map: one word per pin selector, then threshold words, then config
  localparam logic [11:0] SEL_BASE_ADDR = 12'h000;
  localparam logic [11:0] LVL_BASE_ADDR = 12'h100;
  localparam logic [11:0] CFG_ADDR = 12'h200;
  localparam logic [11:0] STAT_ADDR = 12'h204;

  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] LVL_RESET = 8'hff;
  localparam logic [7:0] SEL_FIELD_MASK = 8'h1f;
  // Port E has four pins on the larger package and only pin 3 on the smaller
  localparam logic [7:0] LVL_E_MASK_LARGE = 8'h0f;
  localparam logic [7:0] LVL_E_MASK_SMALL = 8'h08;
  localparam logic [7:0] LVL_FULL_MASK = 8'hff;
  localparam logic [7:0] LVL_NONE_MASK = 8'h00;

  // Config register fields
  localparam int CFG_TWO_WIRE_BIT = 0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Output source selector codes
  typedef enum logic [4:0] {
    POSM_SRC_LATCH = 5'h00,
    POSM_SRC_WG_A = 5'h01,
    POSM_SRC_WG_B = 5'h02,
    POSM_SRC_WG_C = 5'h03,
    POSM_SRC_WG_D = 5'h04,
    POSM_SRC_CAPTURE_COMPARE_ONE = 5'h05,
    POSM_SRC_CAPTURE_COMPARE_TWO = 5'h06,
    POSM_SRC_PM3 = 5'h07,
    POSM_SRC_PM4 = 5'h08,
    POSM_SRC_AS1_TX = 5'h09,
    POSM_SRC_AS1_RX = 5'h0a,
    POSM_SRC_AS2_TX = 5'h0b,
    POSM_SRC_AS2_RX = 5'h0c,
    POSM_SRC_COMPARATOR_ONE = 5'h0d,
    POSM_SRC_COMPARATOR_TWO = 5'h0e,
    POSM_SRC_SS1_CLK = 5'h0f,
    POSM_SRC_SS1_DAT = 5'h10,
    POSM_SRC_SS2_CLK = 5'h11,
    POSM_SRC_SS2_DAT = 5'h12,
    POSM_SRC_TIMER_ZERO_OUT = 5'h13,
    POSM_SRC_REFCLK = 5'h14,
    POSM_SRC_DSM = 5'h15,
    POSM_SRC_GRD_A = 5'h16,
    POSM_SRC_GRD_B = 5'h17
  } posm_src_t;

  // Per-source allowed ports, bit n = port n (A..E); small then large package
  localparam logic [NUM_PORTS-1:0] ALLOW_SMALL [0:NUM_SRC] = '{
    5'h07, 5'h06, 5'h06, 5'h06, 5'h06, 5'h06, 5'h06, 5'h05, 5'h05,
    5'h06, 5'h06, 5'h06, 5'h06, 5'h05, 5'h05, 5'h06, 5'h06, 5'h06,
    5'h06, 5'h06, 5'h06, 5'h05, 5'h05, 5'h05};
  localparam logic [NUM_PORTS-1:0] ALLOW_LARGE [0:NUM_SRC] = '{
    5'h1f, 5'h06, 5'h0a, 5'h0a, 5'h0a, 5'h06, 5'h06, 5'h09, 5'h05,
    5'h06, 5'h06, 5'h0a, 5'h0a, 5'h09, 5'h11, 5'h06, 5'h06, 5'h0a,
    5'h0a, 5'h06, 5'h06, 5'h09, 5'h05, 5'h05};

  // Pins that use the two-wire Schmitt path when picked by the serial port
  localparam logic [NUM_PINS-1:0] TWO_WIRE_PINS = 40'h00_03_18_06_00;

endpackage : posm_pkg

// ---- logic/posm_top.sv ----
/*
  Pin output source multiplexer with per-pin input threshold selection.
  Holds the selector and threshold registers behind an AXI4-Lite slave.
  Assumes peripheral outputs and latches are on clk_sys_i; pin levels arrive
  asynchronously and are synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none

module posm_top
  import posm_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic por_bor_rst_i,
  input wire logic [NUM_PINS-1:0] pin_output_latch_i,
  input wire logic [3:0] waveform_gen_out_i,
  input wire logic capture_compare_one_i,
  input wire logic capture_compare_two_i,
  input wire logic pulse_modulator_three_i,
  input wire logic pulse_modulator_four_i,
  input wire logic [1:0] async_tx_i,
  input wire logic [1:0] async_rx_i,
  input wire logic comparator_one_i,
  input wire logic comparator_two_i,
  input wire logic [1:0] sync_clk_i,
  input wire logic [1:0] sync_dat_i,
  input wire logic timer_zero_out_i,
  input wire logic reference_clock_out_i,
  input wire logic data_signal_modulator_i,
  input wire logic adc_guard_ring_a_i,
  input wire logic adc_guard_ring_b_i,
  input wire logic [NUM_PINS-1:0] sync_port_in_sel_i,
  input wire logic [NUM_PINS-1:0] pin_schmitt_i,
  input wire logic [NUM_PINS-1:0] pin_ttl_i,
  output logic [NUM_PINS-1:0] pin_out_o,
  output logic [NUM_PINS-1:0] pin_in_o,
  output logic [NUM_PINS-1:0] pin_schmitt_sel_o,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam logic [NUM_PORTS-1:0] PORT_PRESENT = LARGE_PACKAGE ? 5'h1f : 5'h17;

  logic [SEL_W-1:0] sel_ff [0:NUM_PINS-1];
  logic [7:0] lvl_ff [0:NUM_PORTS-1];
  logic two_wire_ff;
  logic [NUM_PINS-1:0] schm_meta_ff, schm_sync_ff, ttl_meta_ff, ttl_sync_ff;
  logic [NUM_PINS-1:0] pin_out_ff, pin_in_ff;
  logic [NUM_SRC:0] src_vec;

  // Write channel state: address and data may arrive in either order
  logic aw_held_ff, w_held_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  assign src_vec = {adc_guard_ring_b_i, adc_guard_ring_a_i, data_signal_modulator_i,
                    reference_clock_out_i, timer_zero_out_i,
                    sync_dat_i[1], sync_clk_i[1], sync_dat_i[0], sync_clk_i[0],
                    comparator_two_i, comparator_one_i,
                    async_rx_i[1], async_tx_i[1], async_rx_i[0], async_tx_i[0],
                    pulse_modulator_four_i, pulse_modulator_three_i,
                    capture_compare_two_i, capture_compare_one_i,
                    waveform_gen_out_i, 1'b0};

  // Address decode helpers
  function automatic logic addr_ok(input logic [11:0] a);
    logic [9:0] idx;
    idx = a[11:2];
    if (a[11:8] == SEL_BASE_ADDR[11:8])
      addr_ok = (idx[5:0] < 6'(NUM_PINS)) && PORT_PRESENT[idx[5:3]];
    else if (a[11:8] == LVL_BASE_ADDR[11:8])
      addr_ok = (idx[5:0] < 6'(NUM_PORTS)) && PORT_PRESENT[idx[2:0]];
    else
      addr_ok = (a[11:2] == CFG_ADDR[11:2]) || (a[11:2] == STAT_ADDR[11:2]);
  endfunction : addr_ok

  function automatic logic [7:0] lvl_mask(input int p);
    if (p == PORT_E)
      lvl_mask = LARGE_PACKAGE ? LVL_E_MASK_LARGE : LVL_E_MASK_SMALL;
    else if (PORT_PRESENT[p])
      lvl_mask = LVL_FULL_MASK;
    else
      lvl_mask = LVL_NONE_MASK;
  endfunction : lvl_mask

  logic wr_fire;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= addr_ok(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Selectors reset only by POR/BOR, so a plain system reset keeps pin routing
  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_sel
      always_ff @(posedge clk_sys_i) begin
        if (por_bor_rst_i) begin
          sel_ff[i] <= SEL_RESET[SEL_W-1:0];
        end else if (wr_fire && wstrb_ff[0] && addr_ok(awaddr_ff) &&
                     awaddr_ff[11:8] == SEL_BASE_ADDR[11:8] &&
                     awaddr_ff[7:2] == 6'(i)) begin
          sel_ff[i] <= wdata_ff[SEL_W-1:0];
        end
      end
    end
  endgenerate

  // Threshold bits come up Schmitt on POR/BOR and keep their value otherwise
  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_lvl
      always_ff @(posedge clk_sys_i) begin
        if (por_bor_rst_i) begin
          lvl_ff[p] <= LVL_RESET & lvl_mask(p);
        end else if (wr_fire && wstrb_ff[0] && addr_ok(awaddr_ff) &&
                     awaddr_ff[11:8] == LVL_BASE_ADDR[11:8] &&
                     awaddr_ff[7:2] == 6'(p)) begin
          lvl_ff[p] <= wdata_ff[7:0] & lvl_mask(p);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      two_wire_ff <= 1'b0;
    end else if (wr_fire && wstrb_ff[0] && awaddr_ff[11:2] == CFG_ADDR[11:2]) begin
      two_wire_ff <= wdata_ff[CFG_TWO_WIRE_BIT];
    end
  end

  // Read channel; status word reports the package variant
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (!addr_ok(s_axi_araddr)) begin
        rdata_ff <= 32'h0000_0000;
      end else if (s_axi_araddr[11:8] == SEL_BASE_ADDR[11:8]) begin
        rdata_ff <= {27'h0, sel_ff[s_axi_araddr[7:2]]};
      end else if (s_axi_araddr[11:8] == LVL_BASE_ADDR[11:8]) begin
        rdata_ff <= {24'h0, lvl_ff[s_axi_araddr[4:2]]};
      end else if (s_axi_araddr[11:2] == CFG_ADDR[11:2]) begin
        rdata_ff <= {31'h0, two_wire_ff};
      end else begin
        rdata_ff <= {31'h0, LARGE_PACKAGE};
      end
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Pin levels are asynchronous: two flops before use
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      schm_meta_ff <= '0;
      schm_sync_ff <= '0;
      ttl_meta_ff <= '0;
      ttl_sync_ff <= '0;
    end else begin
      schm_meta_ff <= pin_schmitt_i;
      schm_sync_ff <= schm_meta_ff;
      ttl_meta_ff <= pin_ttl_i;
      ttl_sync_ff <= ttl_meta_ff;
    end
  end

  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      localparam int PORT = i / PINS_PER_PORT;
      logic [NUM_PORTS-1:0] allow;
      logic legal, use_schm;
      assign allow = LARGE_PACKAGE ? ALLOW_LARGE[sel_ff[i]] : ALLOW_SMALL[sel_ff[i]];
      assign legal = (sel_ff[i] <= 5'(NUM_SRC)) && allow[PORT];
      // Two-wire mode overrides the threshold bit on the marked pins
      assign use_schm = lvl_ff[PORT][i % PINS_PER_PORT] ||
                        (TWO_WIRE_PINS[i] && two_wire_ff && sync_port_in_sel_i[i]);
      assign pin_schmitt_sel_o[i] = use_schm;

      always_ff @(posedge clk_sys_i) begin
        if (rst_i || !PORT_PRESENT[PORT]) begin
          pin_out_ff[i] <= 1'b0;
          pin_in_ff[i] <= 1'b0;
        end else begin
          if (sel_ff[i] == POSM_SRC_LATCH || !legal)
            pin_out_ff[i] <= pin_output_latch_i[i];
          else
            pin_out_ff[i] <= src_vec[sel_ff[i]];
          pin_in_ff[i] <= use_schm ? schm_sync_ff[i] : ttl_sync_ff[i];
        end
      end
    end
  endgenerate

  assign pin_out_o = pin_out_ff;
  assign pin_in_o = pin_in_ff;

endmodule : posm_top

`default_nettype wire

// ---- tb/posm_src_model.sv ----
/*
  Model of the on-chip peripheral outputs feeding the pin multiplexer.
  Assumes the system clock and reset of the block; index n is code n+1.
*/
`timescale 1ns/10ps
`default_nettype none

module posm_src_model (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic [22:0] src_o
);
  // A shifting LFSR, so that a neighbouring code never matches for long
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_o <= 23'h2a5c31;
    end else begin
      src_o <= {src_o[21:0], src_o[22] ^ src_o[17]};
    end
  end
endmodule : posm_src_model

`default_nettype wire

// ---- tb/posm_top_sva.sv ----
/*
  Checker for the ports of posm_top: bus handshakes, reset defaults, input path.
  Assumes it is bound into posm_top and sees one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module posm_top_chk
  import posm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic por_bor_rst_i,
  input wire logic [NUM_PINS-1:0] pin_output_latch_i,
  input wire logic [NUM_PINS-1:0] pin_schmitt_i,
  input wire logic [NUM_PINS-1:0] pin_ttl_i,
  input wire logic [NUM_PINS-1:0] pin_out_o,
  input wire logic [NUM_PINS-1:0] pin_in_o,
  input wire logic [NUM_PINS-1:0] pin_schmitt_sel_o,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic clean_ff;
  logic [2:0] quiet_ff;
  logic [NUM_PINS-1:0] latch_q_ff;
  logic [NUM_PINS-1:0] mix;
  assign mix = (pin_schmitt_i & pin_schmitt_sel_o) | (pin_ttl_i & ~pin_schmitt_sel_o);
  // Any write response may have moved a selector, so the default check stops
  always_ff @(posedge clk_sys_i) begin
    if (por_bor_rst_i) clean_ff <= 1'b1;
    else if (s_axi_bvalid) clean_ff <= 1'b0;
  end
  always_ff @(posedge clk_sys_i) begin
    latch_q_ff <= pin_output_latch_i;
  end
  // Counts edges with pins and selection steady, to outlast the synchroniser
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !$stable(pin_schmitt_i) || !$stable(pin_ttl_i) || !$stable(pin_schmitt_sel_o))
      quiet_ff <= 3'h0;
    else if (quiet_ff != 3'h7) quiet_ff <= quiet_ff + 3'h1;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed before rready");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer one cycle after address");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("no write response in two cycles");
  aw_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
  ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  latch_default_a: assert property (clean_ff && !$past(rst_i) |->
    pin_out_o[23:0] == latch_q_ff[23:0]) else $error("pin not from latch after power-on");
  // The counter lags one edge, so the current edge must be steady as well
  thresh_path_a: assert property (quiet_ff > 3'h4 && $stable(pin_schmitt_i) &&
    $stable(pin_ttl_i) && $stable(pin_schmitt_sel_o) |-> pin_in_o[23:0] == mix[23:0])
    else $error("pin read not from selected threshold");
endmodule : posm_top_chk

bind posm_top posm_top_chk chk (.clk_sys_i, .rst_i, .por_bor_rst_i, .pin_output_latch_i,
  .pin_schmitt_i, .pin_ttl_i, .pin_out_o, .pin_in_o, .pin_schmitt_sel_o, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

`default_nettype wire

// ---- tb/tb_posm_top.sv ----
/*
  Testbench for posm_top: registers over AXI4-Lite, routing, resets, thresholds.
  Assumes posm_src_model drives every peripheral source.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_posm_top
  import posm_pkg::*;
;
  localparam logic [23:0] ON_B = 24'h1f9e7e;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, por_bor_rst_i = 1'b1;
  logic [NUM_PINS-1:0] pin_output_latch_i = 40'h963ca55ac3, sync_port_in_sel_i = '0;
  logic [NUM_PINS-1:0] pin_schmitt_i = '0, pin_ttl_i = '0, pin_out_o, pin_in_o;
  logic [NUM_PINS-1:0] pin_schmitt_sel_o;
  logic [22:0] src;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  int n_mismatch = 0, cmp_count = 0;

  posm_src_model src_m (.clk_i(clk_sys_i), .rst_i, .src_o(src));
  posm_top dut (.clk_sys_i, .rst_i, .por_bor_rst_i, .pin_output_latch_i,
    .waveform_gen_out_i(src[3:0]), .capture_compare_one_i(src[4]),
    .capture_compare_two_i(src[5]), .pulse_modulator_three_i(src[6]),
    .pulse_modulator_four_i(src[7]), .async_tx_i({src[10], src[8]}),
    .async_rx_i({src[11], src[9]}), .comparator_one_i(src[12]), .comparator_two_i(src[13]),
    .sync_clk_i({src[16], src[14]}), .sync_dat_i({src[17], src[15]}),
    .timer_zero_out_i(src[18]), .reference_clock_out_i(src[19]),
    .data_signal_modulator_i(src[20]), .adc_guard_ring_a_i(src[21]),
    .adc_guard_ring_b_i(src[22]), .sync_port_in_sel_i, .pin_schmitt_i, .pin_ttl_i,
    .pin_out_o, .pin_in_o, .pin_schmitt_sel_o, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic end_of_test;
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Response ready goes up with the request and falls after its handshake edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, bv, tb;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk_sys_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      tb = bv && s_axi_bready;
      if (tb) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      @(posedge clk_sys_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
  endtask : wr

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e,
    input logic [1:0] er);
    logic ta, rv, tv;
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tv = 1'b0;
    while (!tv) begin
      @(negedge clk_sys_i);
      ta = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      tv = rv && s_axi_rready;
      if (tv) chk(nm, e, s_axi_rdata);
      if (tv) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      @(posedge clk_sys_i);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tv) s_axi_rready <= 1'b0;
    end
  endtask : rchk

  task automatic t_defaults;
    rchk("sel pin0", SEL_BASE_ADDR, 32'h0, RESP_OKAY);
    rchk("lvl a", LVL_BASE_ADDR, 32'hff, RESP_OKAY);
    rchk("lvl d", LVL_BASE_ADDR + 12'hc, 32'hff, RESP_OKAY);
    rchk("lvl e", LVL_BASE_ADDR + 12'h10, {24'h0, LVL_E_MASK_LARGE}, RESP_OKAY);
    rchk("status", STAT_ADDR, 32'h1, RESP_OKAY);
    rchk("unmapped", 12'h300, 32'h0, RESP_SLVERR);
    wr(12'h300, 32'h1, RESP_SLVERR);
    wr(SEL_BASE_ADDR + 12'h24, 32'hffffffff, RESP_OKAY);
    rchk("sel field", SEL_BASE_ADDR + 12'h24, 32'h1f, RESP_OKAY);
  endtask : t_defaults

  task automatic route(input int p, input int c, input bit lat);
    logic [22:0] s;
    wr(SEL_BASE_ADDR + 12'(4 * p), {27'h0, 5'(c)}, RESP_OKAY);
    pin_output_latch_i <= ~pin_output_latch_i;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    repeat (4) begin
      s = src;
      @(negedge clk_sys_i);
      chk("pin out", {31'h0, lat ? pin_output_latch_i[p] : s[c - 1]}, {31'h0, pin_out_o[p]});
    end
  endtask : route

  task automatic t_routes;
    for (int c = 0; c < 24; c++) begin
      route(ON_B[c] ? 8 : 0, c, c == 0);
    end
    route(0, 1, 1'b1);
    route(8, 24, 1'b1);
    route(16, 2, 1'b1);
  endtask : t_routes

  task automatic do_reset(input bit por);
    rst_i <= 1'b1;
    por_bor_rst_i <= por;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    por_bor_rst_i <= 1'b0;
  endtask : do_reset

  task automatic t_resets;
    wr(SEL_BASE_ADDR + 12'h24, 32'h5, RESP_OKAY);
    do_reset(1'b0);
    rchk("sel kept", SEL_BASE_ADDR + 12'h24, 32'h5, RESP_OKAY);
    do_reset(1'b1);
    rchk("sel cleared", SEL_BASE_ADDR + 12'h24, 32'h0, RESP_OKAY);
  endtask : t_resets

  task automatic t_levels;
    wr(LVL_BASE_ADDR, 32'h0f, RESP_OKAY);
    pin_schmitt_i <= '1;
    repeat (6) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("schmitt sel a", 32'h0f, {24'h0, pin_schmitt_sel_o[7:0]});
    chk("pin in a", 32'h0f, {24'h0, pin_in_o[7:0]});
    wr(LVL_BASE_ADDR + 12'h4, 32'h0, RESP_OKAY);
    sync_port_in_sel_i <= 40'he00;
    wr(CFG_ADDR, 32'h1, RESP_OKAY);
    @(negedge clk_sys_i);
    chk("two wire on", 32'h6, {28'h0, pin_schmitt_sel_o[11:8]});
    wr(CFG_ADDR, 32'h0, RESP_OKAY);
    @(negedge clk_sys_i);
    chk("two wire off", 32'h0, {28'h0, pin_schmitt_sel_o[11:8]});
  endtask : t_levels

  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    por_bor_rst_i <= 1'b0;
    t_defaults();
    t_routes();
    t_resets();
    t_levels();
    end_of_test();
  end

  // The whole sequence needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_posm_top

`default_nettype wire
